// ===== bench/bboe_exec_chk.sv
// Concurrent checks on the ports of the bit and byte executor.
`timescale 1ns/1ps
module bboe_exec_chk
   import bboe_pkg::*;
(
   input logic clk,
   input logic resetn,
   input logic instr_valid,
   input logic [bboe_pkg::BBOE_WORD_W-1:0] instr_word,
   input logic instr_ready,
   input logic retire_valid,
   input logic retire_squash,
   input logic skip_taken,
   input bboe_pkg::bboe_axi_req_t axi_req,
   input bboe_pkg::bboe_axi_rsp_t axi_rsp
);
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // A word is taken at this edge.
   sequence s_take;
      instr_valid && instr_ready;
   endsequence

   // A skip is flagged while the next word is being taken.
   sequence s_skip_take;
      skip_taken && instr_valid && instr_ready;
   endsequence

   retire_one_a: assert property (s_take |=> retire_valid)
      else $error("taken word did not retire next cycle");
   retire_only_a: assert property (!(instr_valid && instr_ready)
      |=> !retire_valid) else $error("retire without a taken word");
   skip_cause_a: assert property (skip_taken |->
      $past(instr_valid) && $past(instr_word[13:10]) == BBOE_CODE_BTSC)
      else $error("skip flagged without a bit test");
   skip_retire_a: assert property (skip_taken |-> retire_valid
      && !retire_squash) else $error("skip without its own retire");
   squash_next_a: assert property (s_skip_take |=> retire_squash)
      else $error("word after a skip was not dropped");
   squash_once_a: assert property (retire_squash ##0 s_take
      |=> !retire_squash) else $error("two words dropped");
   squash_retire_a: assert property (retire_squash |-> retire_valid
      && !skip_taken) else $error("drop without retire");
   read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid) else $error("read answer late");
   ready_reset_a: assert property ($rose(resetn) |-> instr_ready)
      else $error("instruction port not ready after reset");
endmodule : bboe_exec_chk

bind bboe_exec bboe_exec_chk u_bboe_exec_chk (.clk(clk), .resetn(resetn),
   .instr_valid(instr_valid), .instr_word(instr_word),
   .instr_ready(instr_ready), .retire_valid(retire_valid),
   .retire_squash(retire_squash), .skip_taken(skip_taken),
   .axi_req(axi_req), .axi_rsp(axi_rsp));

// ===== bench/bboe_fetch_model.sv
// Instruction fetch model that offers program words to the executor.
`timescale 1ns/1ps
module bboe_fetch_model
   import bboe_pkg::*;
(
   input logic clk,
   input logic instr_ready,
   output logic instr_valid,
   output logic [bboe_pkg::BBOE_WORD_W-1:0] instr_word
);
   logic [BBOE_WORD_W-1:0] prog_q[$];
   int gap;

   // Lines start idle; idle words are the inverse of the last one.
   initial
   begin
      instr_valid = 1'b0;
      instr_word = '0;
      gap = 0;
   end

   // Offers queued words, each held until taken, with optional idle gaps.
   task automatic stream;
      @(posedge clk);
      while (prog_q.size() > 0)
      begin
         instr_valid <= 1'b1;
         instr_word <= prog_q.pop_front();
         do @(negedge clk); while (instr_ready !== 1'b1);
         @(posedge clk);
         if (gap > 0)
         begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
            repeat (gap) @(posedge clk);
         end
      end
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
   endtask : stream
endmodule : bboe_fetch_model

// ===== bench/tb_top.sv
// Self-checking bench for the bit and byte executor.
`timescale 1ns/1ps
module tb_top;
   import bboe_pkg::*;
   logic clk;
   logic resetn;
   logic instr_valid;
   logic [BBOE_WORD_W-1:0] instr_word;
   logic instr_ready;
   logic retire_valid;
   logic retire_squash;
   logic skip_taken;
   bboe_axi_req_t axi_req;
   bboe_axi_rsp_t axi_rsp;
   int error_cnt;
   int comparisons;
   int skip_cnt = 0;
   int squash_cnt = 0;
   logic [1:0] resp;
   logic [31:0] rd;
   logic [BBOE_WORD_W-1:0] prog[$];

   bboe_exec u_bboe_exec (.clk(clk), .resetn(resetn),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .retire_valid(retire_valid),
      .retire_squash(retire_squash), .skip_taken(skip_taken),
      .axi_req(axi_req), .axi_rsp(axi_rsp));
   bboe_fetch_model u_bboe_fetch_model (.clk(clk),
      .instr_ready(instr_ready), .instr_valid(instr_valid),
      .instr_word(instr_word));

   // ****
   // Clock, counters and tasks
   // ****
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Counts skip and drop pulses where they are settled.
   always @(negedge clk)
   begin
      if (skip_taken === 1'b1) skip_cnt++;
      if (retire_squash === 1'b1 && retire_valid === 1'b1) squash_cnt++;
   end

   // Cuts a hang short.
   initial
   begin
      #200000;
      error_cnt++;
      complete_run();
   end

   task automatic complete_run;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic check(input string n, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check

   // Write: address and data offered together, each dropped once taken.
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_t;
      logic w_t;
      @(posedge clk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.bready <= 1'b1;
      do
      begin
         @(negedge clk);
         aw_t = axi_req.awvalid & axi_rsp.awready;
         w_t = axi_req.wvalid & axi_rsp.wready;
         @(posedge clk);
         if (aw_t) axi_req.awvalid <= 1'b0;
         if (w_t) axi_req.wvalid <= 1'b0;
      end
      while (axi_req.awvalid | axi_req.wvalid);
      do @(negedge clk); while (axi_rsp.bvalid !== 1'b1);
      resp = axi_rsp.bresp;
      @(posedge clk);
      axi_req.bready <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk);
      axi_req.arvalid <= 1'b1;
      axi_req.araddr <= a;
      axi_req.rready <= 1'b1;
      do @(negedge clk); while (axi_rsp.arready !== 1'b1);
      @(posedge clk);
      axi_req.arvalid <= 1'b0;
      do @(negedge clk); while (axi_rsp.rvalid !== 1'b1);
      rd = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      @(posedge clk);
      axi_req.rready <= 1'b0;
   endtask : bus_rd

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] v);
      bus_rd(a);
      check("register", v, rd);
   endtask : reg_chk

   task automatic file_wr(input logic [6:0] f, input logic [7:0] v);
      bus_wr(BBOE_OFF_FADDR, {25'h0, f});
      bus_wr(BBOE_OFF_FDATA, {24'h0, v});
   endtask : file_wr

   task automatic file_chk(input logic [6:0] f, input logic [7:0] v);
      bus_wr(BBOE_OFF_FADDR, {25'h0, f});
      bus_rd(BBOE_OFF_FDATA);
      check("file", {24'h0, v}, rd);
   endtask : file_chk

   // Streams the program and lets the last word retire.
   task automatic run(input logic [BBOE_WORD_W-1:0] w[$]);
      u_bboe_fetch_model.prog_q = w;
      u_bboe_fetch_model.stream();
      repeat (2) @(posedge clk);
   endtask : run

   function automatic logic [13:0] op_b(input logic [5:0] c,
      input logic d, input logic [6:0] f);
      return {c, d, f};
   endfunction : op_b

   function automatic logic [13:0] op_t(input logic [3:0] c,
      input logic [2:0] b, input logic [6:0] f);
      return {c, b, f};
   endfunction : op_t

   // ****
   // Main sequence
   // ****
   initial
   begin
      axi_req = '0;
      resetn = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      reg_chk(BBOE_OFF_CTRL, 32'h1);
      reg_chk(BBOE_OFF_FLAGS, 32'h0);
      bus_rd(8'h18);
      check("read resp", 32'(BBOE_RESP_SLVERR), 32'(resp));
      bus_wr(8'h18, 32'h0);
      check("write resp", 32'(BBOE_RESP_SLVERR), 32'(resp));
      // Add with the sum kept in the accumulator, all flags set.
      bus_wr(BBOE_OFF_ACC, 32'h99);
      file_wr(7'h05, 8'h67);
      run('{op_b(BBOE_CODE_ADD, 1'b0, 7'h05)});
      reg_chk(BBOE_OFF_ACC, 32'h0);
      reg_chk(BBOE_OFF_FLAGS, 32'h7);
      file_chk(7'h05, 8'h67);
      // Add into the top file address.
      bus_wr(BBOE_OFF_ACC, 32'h17);
      file_wr(7'h7f, 8'h01);
      run('{op_b(BBOE_CODE_ADD, 1'b1, 7'h7f)});
      file_chk(7'h7f, 8'h18);
      reg_chk(BBOE_OFF_ACC, 32'h17);
      reg_chk(BBOE_OFF_FLAGS, 32'h0);
      // Two AND words back to back; carry flags must survive.
      bus_wr(BBOE_OFF_FLAGS, 32'h3);
      file_wr(7'h20, 8'hc2);
      run('{op_b(BBOE_CODE_AND, 1'b1, 7'h20),
         op_b(BBOE_CODE_AND, 1'b0, 7'h40)});
      file_chk(7'h20, 8'h02);
      reg_chk(BBOE_OFF_ACC, 32'h0);
      reg_chk(BBOE_OFF_FLAGS, 32'h7);
      // Every bit index cleared and set, with idle gaps between words.
      bus_wr(BBOE_OFF_FLAGS, 32'h5);
      for (int b = 0; b < 8; b++)
      begin
         file_wr(7'(8 + b), 8'hff);
         file_wr(7'(16 + b), 8'h00);
         prog.push_back(op_t(BBOE_CODE_BCLR, 3'(b), 7'(8 + b)));
         prog.push_back(op_t(BBOE_CODE_BSET, 3'(b), 7'(16 + b)));
      end
      u_bboe_fetch_model.gap = 2;
      run(prog);
      u_bboe_fetch_model.gap = 0;
      for (int b = 0; b < 8; b++)
      begin
         file_chk(7'(8 + b), ~(8'h01 << b));
         file_chk(7'(16 + b), 8'h01 << b);
      end
      reg_chk(BBOE_OFF_FLAGS, 32'h5);
      // Bit clear: the following add is dropped, the bit set after it runs.
      bus_wr(BBOE_OFF_FLAGS, 32'h7);
      bus_wr(BBOE_OFF_ACC, 32'h02);
      file_wr(7'h30, 8'hfd);
      file_wr(7'h31, 8'h10);
      run('{op_t(BBOE_CODE_BTSC, 3'h1, 7'h30),
         op_b(BBOE_CODE_ADD, 1'b1, 7'h31),
         op_t(BBOE_CODE_BSET, 3'h0, 7'h31)});
      check("skips", 32'h1, 32'(skip_cnt));
      check("drops", 32'h1, 32'(squash_cnt));
      file_chk(7'h31, 8'h11);
      reg_chk(BBOE_OFF_FLAGS, 32'h7);
      // Bit set: no skip, the add runs.
      run('{op_t(BBOE_CODE_BTSC, 3'h0, 7'h30),
         op_b(BBOE_CODE_ADD, 1'b1, 7'h31)});
      check("skips", 32'h1, 32'(skip_cnt));
      file_chk(7'h31, 8'h13);
      // An unknown word only raises the sticky flag, cleared by a one.
      run('{14'h3fff});
      reg_chk(BBOE_OFF_STAT, 32'h2);
      bus_wr(BBOE_OFF_STAT, 32'h2);
      reg_chk(BBOE_OFF_STAT, 32'h0);
      // Disabling execution takes the instruction port out of service.
      bus_wr(BBOE_OFF_CTRL, 32'h0);
      @(negedge clk);
      check("ready", 32'h0, 32'(instr_ready));
      bus_wr(BBOE_OFF_CTRL, 32'h1);
      @(negedge clk);
      check("ready", 32'h1, 32'(instr_ready));
      complete_run();
   end
endmodule : tb_top

// ===== rtl/bboe_alu.sv
// Arithmetic and bit unit for the bit and byte executor.
`timescale 1ns/1ps
module bboe_alu
   import bboe_pkg::*;
(
   input bboe_pkg::bboe_op_t op,
   input logic [bboe_pkg::BBOE_DATA_W-1:0] acc,
   input logic [bboe_pkg::BBOE_DATA_W-1:0] fval,
   input logic [2:0] bit_idx,
   output logic [bboe_pkg::BBOE_DATA_W-1:0] result,
   output logic carry,
   output logic nib_carry,
   output logic zero,
   output logic bit_val
);

   // ****************************************************************
   // Result and flags
   // ****************************************************************
   logic [BBOE_DATA_W:0] sum;
   logic [4:0] low_sum;

   // The full sum gives the carry, the low nibbles the nibble carry.
   assign sum = {1'b0, acc} + {1'b0, fval}; // RL1
   assign low_sum = {1'b0, acc[3:0]} + {1'b0, fval[3:0]}; // RL1

   // Selects the result by operation; bit ops touch one bit only.
   always_comb
   begin
      result = fval;
      case (op)
         BBOE_OP_ADD: result = sum[BBOE_DATA_W-1:0]; // RL1
         BBOE_OP_AND: result = acc & fval; // RL2
         BBOE_OP_BCLR: result[bit_idx] = 1'b0; // RL4
         BBOE_OP_BSET: result[bit_idx] = 1'b1; // RL4
         default: result = fval;
      endcase
   end

   assign carry = sum[BBOE_DATA_W];
   assign nib_carry = low_sum[4];
   assign zero = (result == '0);
   assign bit_val = fval[bit_idx]; // RL5

endmodule : bboe_alu

// ===== rtl/bboe_exec.sv
// Top of the bit and byte executor with its AXI4-Lite register slave.
`timescale 1ns/1ps
// Function
// (RL1) Add accumulator to file, update C/NC/Z.
// (RL2) AND accumulator with file, update Z only.
// (RL3) Destination bit 0 to accumulator, 1 to file.
// (RL4) Clear or set one file bit, flags untouched.
// (RL5) Test bit, skip next when clear.
// (RL6) Skipped instruction becomes a no-operation.
// (RL7) File address 6:0, bit 9:7, destination 7.
module bboe_exec
   import bboe_pkg::*;
(
   input logic clk,
   input logic resetn,
   input logic instr_valid,
   input logic [bboe_pkg::BBOE_WORD_W-1:0] instr_word,
   output logic instr_ready,
   output logic retire_valid,
   output logic retire_squash,
   output logic skip_taken,
   input bboe_pkg::bboe_axi_req_t axi_req,
   output bboe_pkg::bboe_axi_rsp_t axi_rsp
);
   import bboe_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [BBOE_FILE_N-1:0][BBOE_DATA_W-1:0] file;
      logic [BBOE_DATA_W-1:0] acc;
      logic carry;
      logic nib_carry;
      logic zero;
      logic exec_en;
      logic skip_pend;
      logic unk_seen;
      logic [BBOE_FADDR_W-1:0] faddr;
      logic aw_held;
      logic w_held;
      logic [BBOE_AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      bboe_axi_rsp_t rsp;
      logic instr_ready;
      logic retire_valid;
      logic retire_squash;
      logic skip_taken;
   } bboe_state_t;

   bboe_state_t st_ff;
   bboe_state_t nxt_st;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Merges byte lane 0 of a bus write into an 8-bit register.
   function automatic logic [7:0] bboe_lane0(
      input logic [7:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      return strb[0] ? data[7:0] : old;
   endfunction : bboe_lane0

   // Tells whether a bus address hits the given register word.
   function automatic logic bboe_hit(
      input logic [BBOE_AXI_AW-1:0] addr,
      input logic [7:0] off
   );
      return addr[BBOE_AXI_AW-1:2] == off[BBOE_AXI_AW-1:2];
   endfunction : bboe_hit

   // ****************************************************************
   // Instruction fields and execution unit
   // ****************************************************************
   bboe_op_t op;
   logic [BBOE_FADDR_W-1:0] f_addr;
   logic [2:0] b_idx;
   logic dest_file;
   logic [BBOE_DATA_W-1:0] f_val;
   logic [BBOE_DATA_W-1:0] alu_res;
   logic alu_carry;
   logic alu_nib;
   logic alu_zero;
   logic alu_bit;

   // Splits the word into its operand fields.
   assign op = bboe_decode(instr_word);
   assign f_addr = instr_word[BBOE_F_MSB:BBOE_F_LSB]; // RL7
   assign b_idx = instr_word[BBOE_B_MSB:BBOE_B_LSB]; // RL7
   assign dest_file = instr_word[BBOE_D_BIT]; // RL7
   assign f_val = st_ff.file[f_addr];

   bboe_alu u_alu (
      .op(op),
      .acc(st_ff.acc),
      .fval(f_val),
      .bit_idx(b_idx),
      .result(alu_res),
      .carry(alu_carry),
      .nib_carry(alu_nib),
      .zero(alu_zero),
      .bit_val(alu_bit)
   );

   // ****************************************************************
   // Register read mux
   // ****************************************************************
   logic [31:0] rd_data;
   logic rd_ok;

   // Returns the addressed register; an unmapped word reads zero.
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      if (bboe_hit(axi_req.araddr, BBOE_OFF_CTRL))
      begin
         rd_data[BBOE_CTRL_EXEC_EN] = st_ff.exec_en;
      end
      else if (bboe_hit(axi_req.araddr, BBOE_OFF_ACC))
      begin
         rd_data[BBOE_DATA_W-1:0] = st_ff.acc;
      end
      else if (bboe_hit(axi_req.araddr, BBOE_OFF_FLAGS))
      begin
         rd_data[BBOE_FLAG_CARRY] = st_ff.carry;
         rd_data[BBOE_FLAG_NIB] = st_ff.nib_carry;
         rd_data[BBOE_FLAG_ZERO] = st_ff.zero;
      end
      else if (bboe_hit(axi_req.araddr, BBOE_OFF_FADDR))
      begin
         rd_data[BBOE_FADDR_W-1:0] = st_ff.faddr;
      end
      else if (bboe_hit(axi_req.araddr, BBOE_OFF_FDATA))
      begin
         rd_data[BBOE_DATA_W-1:0] = st_ff.file[st_ff.faddr];
      end
      else if (bboe_hit(axi_req.araddr, BBOE_OFF_STAT))
      begin
         rd_data[BBOE_STAT_SKIP] = st_ff.skip_pend;
         rd_data[BBOE_STAT_UNK] = st_ff.unk_seen;
      end
      else
      begin
         rd_ok = 1'b0;
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic wr_ok;

   // Bus handshakes first, then the instruction, so execution wins.
   always_comb
   begin
      nxt_st = st_ff;
      wr_ok = 1'b1;
      nxt_st.retire_valid = 1'b0;
      nxt_st.retire_squash = 1'b0;
      nxt_st.skip_taken = 1'b0;

      // Write response retires on its handshake.
      if (st_ff.rsp.bvalid && axi_req.bready)
      begin
         nxt_st.rsp.bvalid = 1'b0;
      end

      // Performs a register write once address and data are both held.
      if (st_ff.aw_held && st_ff.w_held && !st_ff.rsp.bvalid)
      begin
         if (bboe_hit(st_ff.awaddr, BBOE_OFF_CTRL))
         begin
            if (st_ff.wstrb[0])
            begin
               nxt_st.exec_en = st_ff.wdata[BBOE_CTRL_EXEC_EN];
            end
         end
         else if (bboe_hit(st_ff.awaddr, BBOE_OFF_ACC))
         begin
            nxt_st.acc = bboe_lane0(st_ff.acc, st_ff.wdata, st_ff.wstrb);
         end
         else if (bboe_hit(st_ff.awaddr, BBOE_OFF_FLAGS))
         begin
            if (st_ff.wstrb[0])
            begin
               nxt_st.carry = st_ff.wdata[BBOE_FLAG_CARRY];
               nxt_st.nib_carry = st_ff.wdata[BBOE_FLAG_NIB];
               nxt_st.zero = st_ff.wdata[BBOE_FLAG_ZERO];
            end
         end
         else if (bboe_hit(st_ff.awaddr, BBOE_OFF_FADDR))
         begin
            if (st_ff.wstrb[0])
            begin
               nxt_st.faddr = st_ff.wdata[BBOE_FADDR_W-1:0];
            end
         end
         else if (bboe_hit(st_ff.awaddr, BBOE_OFF_FDATA))
         begin
            nxt_st.file[st_ff.faddr] = bboe_lane0(
               st_ff.file[st_ff.faddr], st_ff.wdata, st_ff.wstrb);
         end
         else if (bboe_hit(st_ff.awaddr, BBOE_OFF_STAT))
         begin
            // Unknown-opcode flag is cleared by writing one.
            if (st_ff.wstrb[0] && st_ff.wdata[BBOE_STAT_UNK])
            begin
               nxt_st.unk_seen = 1'b0;
            end
         end
         else
         begin
            wr_ok = 1'b0;
         end
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.rsp.bvalid = 1'b1;
         nxt_st.rsp.bresp = wr_ok ? BBOE_RESP_OKAY : BBOE_RESP_SLVERR;
      end

      // Captures write address and write data in either order.
      if (axi_req.awvalid && st_ff.rsp.awready)
      begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && st_ff.rsp.wready)
      begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = axi_req.wdata;
         nxt_st.wstrb = axi_req.wstrb;
      end

      // Read channel answers one cycle after the address is taken.
      if (st_ff.rsp.rvalid && axi_req.rready)
      begin
         nxt_st.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && st_ff.rsp.arready)
      begin
         nxt_st.rsp.rvalid = 1'b1;
         nxt_st.rsp.rdata = rd_data;
         nxt_st.rsp.rresp = rd_ok ? BBOE_RESP_OKAY : BBOE_RESP_SLVERR;
      end

      // Executes one instruction per accepted word.
      if (instr_valid && st_ff.instr_ready)
      begin
         nxt_st.retire_valid = 1'b1;
         if (st_ff.skip_pend)
         begin
            // The word fetched behind a taken skip is dropped.
            nxt_st.skip_pend = 1'b0; // RL6
            nxt_st.retire_squash = 1'b1; // RL6
         end
         else
         begin
            case (op)
               BBOE_OP_ADD:
               begin
                  nxt_st.carry = alu_carry; // RL1
                  nxt_st.nib_carry = alu_nib; // RL1
                  nxt_st.zero = alu_zero; // RL1
                  if (dest_file)
                  begin
                     nxt_st.file[f_addr] = alu_res; // RL3
                  end
                  else
                  begin
                     nxt_st.acc = alu_res; // RL3
                  end
               end
               BBOE_OP_AND:
               begin
                  nxt_st.zero = alu_zero; // RL2
                  if (dest_file)
                  begin
                     nxt_st.file[f_addr] = alu_res; // RL3
                  end
                  else
                  begin
                     nxt_st.acc = alu_res; // RL3
                  end
               end
               BBOE_OP_BCLR, BBOE_OP_BSET:
               begin
                  nxt_st.file[f_addr] = alu_res; // RL4
               end
               BBOE_OP_BTSC:
               begin
                  if (!alu_bit)
                  begin
                     nxt_st.skip_pend = 1'b1; // RL5
                     nxt_st.skip_taken = 1'b1; // RL5
                  end
               end
               default:
               begin
                  // Set wins over a software clear in the same cycle.
                  nxt_st.unk_seen = 1'b1;
               end
            endcase
         end
      end

      // Ready flags follow the held state so nothing is overrun.
      nxt_st.rsp.awready = !nxt_st.aw_held && !nxt_st.rsp.bvalid;
      nxt_st.rsp.wready = !nxt_st.w_held && !nxt_st.rsp.bvalid;
      nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
      nxt_st.instr_ready = nxt_st.exec_en;
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Synchronous reset clears everything, execution starts enabled.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_ff <= '0;
         st_ff.exec_en <= BBOE_EXEC_EN_RESET;
         st_ff.instr_ready <= BBOE_EXEC_EN_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs come straight from the state register.
   assign instr_ready = st_ff.instr_ready;
   assign retire_valid = st_ff.retire_valid;
   assign retire_squash = st_ff.retire_squash;
   assign skip_taken = st_ff.skip_taken;
   assign axi_rsp = st_ff.rsp;

endmodule : bboe_exec

// ===== rtl/bboe_pkg.sv
// Package of constants, types and decode helpers for the bit and byte executor.
package bboe_pkg;

   // ****************************************************************
   // Widths and register map
   // ****************************************************************
   localparam int BBOE_WORD_W = 14;
   localparam int BBOE_DATA_W = 8;
   localparam int BBOE_FILE_N = 128;
   localparam int BBOE_FADDR_W = 7;
   localparam int BBOE_AXI_AW = 8;

   localparam logic [7:0] BBOE_OFF_CTRL = 8'h00;
   localparam logic [7:0] BBOE_OFF_ACC = 8'h04;
   localparam logic [7:0] BBOE_OFF_FLAGS = 8'h08;
   localparam logic [7:0] BBOE_OFF_FADDR = 8'h0c;
   localparam logic [7:0] BBOE_OFF_FDATA = 8'h10;
   localparam logic [7:0] BBOE_OFF_STAT = 8'h14;

   // Bit positions inside the control, flag and status words.
   localparam int BBOE_CTRL_EXEC_EN = 0;
   localparam int BBOE_FLAG_CARRY = 0;
   localparam int BBOE_FLAG_NIB = 1;
   localparam int BBOE_FLAG_ZERO = 2;
   localparam int BBOE_STAT_SKIP = 0;
   localparam int BBOE_STAT_UNK = 1;

   // Reset values.
   localparam logic BBOE_EXEC_EN_RESET = 1'b1;

   // AXI response codes.
   localparam logic [1:0] BBOE_RESP_OKAY = 2'h0;
   localparam logic [1:0] BBOE_RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Instruction word fields
   // ****************************************************************
   localparam int BBOE_F_LSB = 0;
   localparam int BBOE_F_MSB = 6;
   localparam int BBOE_D_BIT = 7;
   localparam int BBOE_B_LSB = 7;
   localparam int BBOE_B_MSB = 9;
   localparam int BBOE_OP_MSB = 13;
   localparam int BBOE_BYTE_OP_LSB = 8;
   localparam int BBOE_BIT_OP_LSB = 10;
   localparam logic [5:0] BBOE_CODE_ADD = 6'h07;
   localparam logic [5:0] BBOE_CODE_AND = 6'h05;
   localparam logic [3:0] BBOE_CODE_BCLR = 4'h4;
   localparam logic [3:0] BBOE_CODE_BSET = 4'h5;
   localparam logic [3:0] BBOE_CODE_BTSC = 4'h6;
   localparam logic [3:0] BBOE_NIB_MAX = 4'hf;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      BBOE_OP_NONE,
      BBOE_OP_ADD,
      BBOE_OP_AND,
      BBOE_OP_BCLR,
      BBOE_OP_BSET,
      BBOE_OP_BTSC
   } bboe_op_t;

   typedef struct packed {
      logic awvalid;
      logic [BBOE_AXI_AW-1:0] awaddr;
      logic [2:0] awprot;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [BBOE_AXI_AW-1:0] araddr;
      logic [2:0] arprot;
      logic rready;
   } bboe_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bboe_axi_rsp_t;

   // Maps an instruction word onto the operation it asks for.
   function automatic bboe_op_t bboe_decode(
      input logic [BBOE_WORD_W-1:0] w
   );
      bboe_op_t op;
      op = BBOE_OP_NONE;
      if (w[BBOE_OP_MSB:BBOE_BYTE_OP_LSB] == BBOE_CODE_ADD)
      begin
         op = BBOE_OP_ADD;
      end
      else if (w[BBOE_OP_MSB:BBOE_BYTE_OP_LSB] == BBOE_CODE_AND)
      begin
         op = BBOE_OP_AND;
      end
      else if (w[BBOE_OP_MSB:BBOE_BIT_OP_LSB] == BBOE_CODE_BCLR)
      begin
         op = BBOE_OP_BCLR;
      end
      else if (w[BBOE_OP_MSB:BBOE_BIT_OP_LSB] == BBOE_CODE_BSET)
      begin
         op = BBOE_OP_BSET;
      end
      else if (w[BBOE_OP_MSB:BBOE_BIT_OP_LSB] == BBOE_CODE_BTSC)
      begin
         op = BBOE_OP_BTSC;
      end
      return op;
   endfunction : bboe_decode

endpackage : bboe_pkg
